// ==== src/dffd_top.sv ====
// Display frame fetch DMA: two fetch channels, FIFOs, palette and unpack
//
// Function
// - Fetched data buffered in a five by 32-bit FIFO per channel.
// - Two channels; second one works only in dual-panel mode.
// - No service request until the block is enabled.
// - Every service is a burst of four 32-bit words.
// - Bottom word split into 4, 8 or 16-bit pixel codes by size.
// - Removing bottom entry shifts remaining entries down one place.
// - Request service when four of five entries are empty.
// - FIFO running dry sets underrun status and interrupt request.
// - Frame buffer starts with 32 or 512 byte palette, then pixels.
// - 8-bit mode loads 256 entries, other modes load 16.
// - Each frame loads the palette first, then pixel data.
// - Palette entries are half-words, two per 32-bit word.
// - Little endian takes low half first, big endian high half.
// - Endian select reorders halves, bytes or nibbles by size, never bits inside an entry.
// - Pixel size taken from bits 13:12 of entry 0 only.
// - Entries 16 to 255 absent outside 8-bit mode, not fetched.
// - Fetch master claims top system bus priority.
// - Size 00 4-bit, 01 8-bit, 10 12/16-bit bypass, 11 reserved.
// - Overshoot burst data flushed from FIFOs at each frame pulse.
`timescale 1ns/1ps
`default_nettype none
module dffd_top #(
    parameter int LEN_W = 24
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // Register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    // Frame timing
    input  wire logic                frame_pulse,
    // High speed system bus master
    output logic                     hs_req,
    output logic      [31:0]         hs_addr,
    output logic                     hs_prio,
    input  wire logic                hs_gnt,
    input  wire logic                hs_rvalid,
    input  wire logic [31:0]         hs_rdata,
    // Palette load
    output logic                     pal_we,
    output logic      [7:0]          pal_addr,
    output logic      [11:0]         pal_data,
    output logic      [1:0]          pixel_size_select,
    // Pixel codes, top and bottom panel
    input  wire logic [1:0]          pix_ready,
    output logic      [1:0]          pix_valid,
    output logic      [15:0]         pix_data_top,
    output logic      [15:0]         pix_data_bot,
    // Status
    output logic                     underrun_irq
);
    import dffd_pkg::*;

    localparam int CW = $clog2(FIFO_DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////
    // Picks element i of a word; big endian counts from the top end
    function automatic logic [15:0] dffd_pick(input logic [31:0] w,
                                              input logic [2:0]  i,
                                              input logic [1:0]  sz,
                                              input logic        big);
        logic [2:0]  pos;
        logic [31:0] sh;
        begin
            pos = big ? (3'd7 - i) : i;
            sh  = w;
            case (sz)
                PSZ_8BIT: begin
                    sh = w >> {(big ? (2'd3 - i[1:0]) : i[1:0]), 3'b000};
                    dffd_pick = {8'h00, sh[7:0]};
                end
                PSZ_16BIT: begin
                    // Halves swap; bits inside a half never move
                    sh = (i[0] ^ big) ? (w >> 16) : w;
                    dffd_pick = sh[15:0];
                end
                default: begin
                    sh = w >> {pos, 2'b00};
                    dffd_pick = {12'h000, sh[3:0]};
                end
            endcase
        end
    endfunction : dffd_pick

    // Last element index within one word for a pixel size
    function automatic logic [2:0] dffd_last(input logic [1:0] sz);
        case (sz)
            PSZ_8BIT:  dffd_last = 3'd3;
            PSZ_16BIT: dffd_last = 3'd1;
            default:   dffd_last = 3'd7; // Reserved code unpacks as 4-bit
        endcase
    endfunction : dffd_last

    ////////////////////////////////////////////////////////////////////////
    // Input FIFOs, one per channel
    logic [CHANNELS-1:0] push;
    logic [CHANNELS-1:0] pop;
    logic [31:0]         bottom [CHANNELS];
    logic [CW-1:0]       cnt    [CHANNELS];
    logic [CHANNELS-1:0] empty;

    for (genvar c = 0; c < CHANNELS; c++) begin : g_fifo
        dffd_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
            .core_clk  (core_clk),
            .rst       (rst),
            .flush     (frame_pulse),
            .push      (push[c]),
            .push_data (hs_rdata),
            .pop       (pop[c]),
            .bottom    (bottom[c]),
            .count     (cnt[c]),
            .empty     (empty[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file state
    logic [2:0]       ctrl, next_ctrl;
    logic [31:0]      base [CHANNELS];
    logic [31:0]      next_base [CHANNELS];
    logic [LEN_W-1:0] len, next_len;
    logic             under, next_under;
    logic [31:0]      next_rdata;
    logic             under_set;
    logic             enable, dual, big;

    assign enable = ctrl[CTRL_ENABLE_BIT];
    assign dual   = ctrl[CTRL_DUAL_BIT];
    assign big    = ctrl[CTRL_ENDIAN_BIT];

    // Fetch engine state
    dffd_dma_state_t  state, next_state;
    logic             ch, next_ch, last_ch, next_last_ch;
    logic [31:0]      addr [CHANNELS];
    logic [31:0]      next_addr [CHANNELS];
    logic [LEN_W-1:0] fetched [CHANNELS];
    logic [LEN_W-1:0] next_fetched [CHANNELS];
    logic [LEN_W-1:0] total [CHANNELS];
    logic [1:0]       beats, next_beats;
    logic             stale, next_stale;
    logic             next_hs_req;
    logic [31:0]      next_hs_addr;
    logic [1:0]       want;

    // Palette and unpack state
    logic             pal_phase, next_pal_phase;
    logic             pal_known, next_pal_known;
    logic [8:0]       pal_idx, next_pal_idx;
    logic [8:0]       pal_lim;
    logic [1:0]       psize, next_psize;
    logic             next_pal_we;
    logic [7:0]       next_pal_addr;
    logic [11:0]      next_pal_data;
    logic [31:0]      hold_w [CHANNELS];
    logic [31:0]      next_hold_w [CHANNELS];
    logic [1:0]       hold_v, next_hold_v;
    logic [2:0]       idx [CHANNELS];
    logic [2:0]       next_idx [CHANNELS];
    logic [15:0]      pix_q [CHANNELS];
    logic [15:0]      next_pix_q [CHANNELS];
    logic [1:0]       next_pix_valid;
    logic [15:0]      elem;
    logic [2:0]       lastix;
    logic             step;

    ////////////////////////////////////////////////////////////////////////
    // Register writes, reads and sticky underrun
    always_comb begin
        next_ctrl  = ctrl;
        next_base  = base;
        next_len   = len;
        next_under = under;
        next_rdata = 32'h0000_0000;
        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL:   next_ctrl    = reg_wdata[2:0];
                REG_BASE0:  next_base[0] = reg_wdata;
                REG_BASE1:  next_base[1] = reg_wdata;
                REG_LEN:    next_len     = reg_wdata[LEN_W-1:0];
                REG_STATUS: begin
                    if (reg_wdata[STAT_UNDER_BIT]) begin
                        next_under = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // A new underrun beats a clear in the same cycle
        if (under_set) begin
            next_under = 1'b1;
        end
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:   next_rdata = {29'h0, ctrl};
                REG_BASE0:  next_rdata = base[0];
                REG_BASE1:  next_rdata = base[1];
                REG_LEN:    next_rdata = 32'(len);
                REG_STATUS: next_rdata = {21'h0, cnt[1], cnt[0],
                                          state != DMA_IDLE, psize,
                                          pal_phase, under};
                default:    next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl      <= CTRL_RESET;
            base[0]   <= BASE_RESET;
            base[1]   <= BASE_RESET;
            len       <= LEN_RESET;
            under     <= 1'b0;
            reg_rdata <= 32'h0000_0000;
            underrun_irq <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            base      <= next_base;
            len       <= next_len;
            under     <= next_under;
            reg_rdata <= next_rdata;
            underrun_irq <= next_under;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fetch engine: linear reads from each channel base, palette included
    always_comb begin
        next_state   = state;
        next_ch      = ch;
        next_last_ch = last_ch;
        next_addr    = addr;
        next_fetched = fetched;
        next_beats   = beats;
        next_stale   = stale;
        next_hs_req  = hs_req;
        next_hs_addr = hs_addr;
        // Palette words ride ahead of pixels on channel 0 only
        total[0] = len + LEN_W'((pal_known && psize == PSZ_8BIT) ?
                          PAL_WORDS_FULL : PAL_WORDS_SMALL);
        total[1] = len;
        for (int c = 0; c < CHANNELS; c++) begin
            want[c] = enable && (c == 0 || dual) &&
                      cnt[c] <= CW'(FIFO_DEPTH - BURST_WORDS) &&
                      fetched[c] < total[c];
        end
        case (state)
            DMA_IDLE: begin
                if (want != 2'b00 && !frame_pulse) begin
                    // Both waiting: serve the one not served last
                    next_ch = (want == 2'b11) ? !last_ch : want[1];
                    next_last_ch = next_ch;
                    next_hs_req  = 1'b1;
                    next_hs_addr = addr[next_ch];
                    next_state   = DMA_REQ;
                end
            end
            DMA_REQ: begin
                if (hs_gnt) begin
                    next_hs_req      = 1'b0;
                    next_addr[ch]    = addr[ch] + BURST_BYTES;
                    next_fetched[ch] = fetched[ch] + LEN_W'(BURST_WORDS);
                    next_beats       = 2'd0;
                    next_state       = DMA_DATA;
                end
            end
            DMA_DATA: begin
                if (hs_rvalid) begin
                    next_beats = beats + 2'd1;
                    if (beats == 2'(BURST_WORDS - 1)) begin
                        next_state = DMA_IDLE;
                        next_stale = 1'b0;
                    end
                end
            end
            default: next_state = DMA_IDLE;
        endcase
        // Frame pulse restarts both channels; a burst in flight is dropped
        if (frame_pulse) begin
            next_addr    = base;
            next_fetched = '{default: '0};
            next_stale   = (next_state != DMA_IDLE);
        end
        for (int c = 0; c < CHANNELS; c++) begin
            push[c] = hs_rvalid && state == DMA_DATA && !stale && ch == c;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state   <= DMA_IDLE;
            ch      <= 1'b0;
            last_ch <= 1'b1;
            addr    <= '{default: '0};
            fetched <= '{default: '0};
            beats   <= 2'd0;
            stale   <= 1'b0;
            hs_req  <= 1'b0;
            hs_addr <= 32'h0000_0000;
            hs_prio <= 1'b1;
        end else begin
            state   <= next_state;
            ch      <= next_ch;
            last_ch <= next_last_ch;
            addr    <= next_addr;
            fetched <= next_fetched;
            beats   <= next_beats;
            stale   <= next_stale;
            hs_req  <= next_hs_req;
            hs_addr <= next_hs_addr;
            hs_prio <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Palette load then unpack, per panel
    always_comb begin
        next_pal_phase = pal_phase;
        next_pal_known = pal_known;
        next_pal_idx   = pal_idx;
        next_psize     = psize;
        next_pal_we    = 1'b0;
        next_pal_addr  = pal_addr;
        next_pal_data  = pal_data;
        next_hold_w    = hold_w;
        next_hold_v    = hold_v;
        next_idx       = idx;
        next_pix_q     = pix_q;
        next_pix_valid = 2'b00;
        pop            = 2'b00;
        under_set      = 1'b0;
        elem           = 16'h0000;
        pal_lim        = PAL_LAST_SMALL;
        lastix         = 3'd0;
        step           = 1'b0;
        for (int p = 0; p < CHANNELS; p++) begin
            lastix = (p == 0 && pal_phase) ? 3'd1 : dffd_last(psize);
            step   = hold_v[p] && ((p == 0 && pal_phase) ||
                     (!pal_phase && pix_ready[p]));
            elem   = dffd_pick(hold_w[p], idx[p],
                               pal_phase ? PSZ_16BIT : psize, big);
            if (step && pal_phase) begin
                next_pal_we   = 1'b1;
                next_pal_addr = pal_idx[7:0];
                next_pal_data = elem[11:0];
                if (pal_idx == 9'h000) begin
                    next_psize     = elem[PSZ_HI:PSZ_LO];
                    next_pal_known = 1'b1;
                end
                pal_lim = ((pal_idx == 9'h000 ? elem[PSZ_HI:PSZ_LO] : psize)
                           == PSZ_8BIT) ? PAL_LAST_FULL : PAL_LAST_SMALL;
                next_pal_idx = pal_idx + 9'h001;
                if (pal_idx == pal_lim) begin
                    next_pal_phase = 1'b0;
                end
            end else if (step) begin
                next_pix_q[p]     = elem;
                next_pix_valid[p] = 1'b1;
            end
            if (step) begin
                next_idx[p]    = (idx[p] == lastix) ? 3'd0 : idx[p] + 3'd1;
                next_hold_v[p] = (idx[p] != lastix);
            end
            // Refill from the FIFO bottom as the held word runs out
            if ((!hold_v[p] || (step && idx[p] == lastix)) && !empty[p]) begin
                pop[p]         = 1'b1;
                next_hold_w[p] = bottom[p];
                next_hold_v[p] = 1'b1;
                next_idx[p]    = 3'd0;
            end
            // Only counts once fetching has begun, not during start-up
            if (enable && !pal_phase && (p == 0 || dual) && pix_ready[p] &&
                !hold_v[p] && empty[p] && fetched[p] != '0) begin
                under_set = 1'b1;
            end
        end
        if (frame_pulse) begin
            next_pal_phase = 1'b1;
            next_pal_known = 1'b0;
            next_pal_idx   = 9'h000;
            next_hold_v    = 2'b00;
            next_idx       = '{default: '0};
            pop            = 2'b00;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pal_phase <= 1'b1;
            pal_known <= 1'b0;
            pal_idx   <= 9'h000;
            psize     <= PSZ_4BIT;
            pal_we    <= 1'b0;
            pal_addr  <= 8'h00;
            pal_data  <= 12'h000;
            hold_w    <= '{default: '0};
            hold_v    <= 2'b00;
            idx       <= '{default: '0};
            pix_q     <= '{default: '0};
            pix_valid <= 2'b00;
        end else begin
            pal_phase <= next_pal_phase;
            pal_known <= next_pal_known;
            pal_idx   <= next_pal_idx;
            psize     <= next_psize;
            pal_we    <= next_pal_we;
            pal_addr  <= next_pal_addr;
            pal_data  <= next_pal_data;
            hold_w    <= next_hold_w;
            hold_v    <= next_hold_v;
            idx       <= next_idx;
            pix_q     <= next_pix_q;
            pix_valid <= next_pix_valid;
        end
    end

    assign pixel_size_select = psize;
    assign pix_data_top      = pix_q[0];
    assign pix_data_bot      = pix_q[1];

endmodule : dffd_top
`default_nettype wire

// ==== src/dffd_pkg.sv ====
// Shared constants and types of the display frame fetch DMA
package dffd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Structure
    localparam int FIFO_DEPTH  = 5;
    localparam int FIFO_WIDTH  = 32;
    localparam int CHANNELS    = 2;
    localparam int BURST_WORDS = 4;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_BASE0  = 8'h04;
    localparam logic [7:0] REG_BASE1  = 8'h08;
    localparam logic [7:0] REG_LEN    = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // Control and status bit positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_DUAL_BIT   = 1;
    localparam int CTRL_ENDIAN_BIT = 2;
    localparam int STAT_UNDER_BIT  = 0;

    // Values after reset
    localparam logic [2:0]  CTRL_RESET = 3'h0;
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    localparam logic [23:0] LEN_RESET  = 24'h00_0000;

    ////////////////////////////////////////////////////////////////////////
    // Palette entry layout and sizes
    localparam int PSZ_HI = 13;
    localparam int PSZ_LO = 12;
    localparam logic [1:0] PSZ_4BIT  = 2'b00;
    localparam logic [1:0] PSZ_8BIT  = 2'b01;
    localparam logic [1:0] PSZ_16BIT = 2'b10;
    localparam logic [8:0] PAL_LAST_SMALL = 9'h00f;
    localparam logic [8:0] PAL_LAST_FULL  = 9'h0ff;
    localparam logic [23:0] PAL_WORDS_SMALL = 24'h00_0008;
    localparam logic [23:0] PAL_WORDS_FULL  = 24'h00_0080;
    localparam logic [31:0] BURST_BYTES = 32'h0000_0010;

    // Fetch engine states
    typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_DATA} dffd_dma_state_t;

endpackage : dffd_pkg

// ==== src/dffd_fifo.sv ====
// Shift-down input FIFO, read from the bottom entry
`timescale 1ns/1ps
`default_nettype none
module dffd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 5,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Control
    input  wire logic             flush,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    // State
    output logic      [WIDTH-1:0] bottom,
    output logic      [CW-1:0]    count,
    output logic                  empty
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [CW-1:0]    next_count;
    logic [CW-1:0]    fill;

    ////////////////////////////////////////////////////////////////////////
    // Pop shifts all entries down; push lands on top of what is left
    always_comb begin
        fill = count;
        for (int i = 0; i < DEPTH; i++) begin
            next_mem[i] = mem[i];
        end
        if (pop && count != '0) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_mem[i] = mem[i + 1];
            end
            next_mem[DEPTH-1] = '0;
            fill = count - 1'b1;
        end
        next_count = fill;
        // Writes when full are dropped; the fetch engine never does that
        if (push && fill != CW'(DEPTH)) begin
            next_mem[fill] = push_data;
            next_count = fill + 1'b1;
        end
        if (flush) begin
            next_count = '0;
        end
    end

    // Register stage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            count <= next_count;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= next_mem[i];
            end
        end
    end

    assign bottom = mem[0];
    assign empty  = (count == '0);

endmodule : dffd_fifo
`default_nettype wire

// ==== sim/dffd_asserts.sv ====
// Port checker of the frame fetch DMA
`timescale 1ns/1ps
`default_nettype none
module dffd_asserts (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // Watched ports
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        hs_req,
    input wire logic        hs_gnt,
    input wire logic        hs_rvalid,
    input wire logic        hs_prio,
    input wire logic [31:0] hs_addr,
    input wire logic        frame_pulse,
    input wire logic        pal_we,
    input wire logic [1:0]  pix_ready,
    input wire logic [1:0]  pix_valid,
    input wire logic        underrun_irq
);
    import dffd_pkg::*;
    logic [2:0] beats;
    logic [2:0] next_beats;
    wire        wclr = reg_wr && reg_wdata[0] && reg_addr == REG_STATUS;
    // Beats still owed after a grant
    always_comb begin
        next_beats = beats;
        if (hs_req && hs_gnt) next_beats = 3'h4;
        else if (hs_rvalid && beats != 3'h0) next_beats = beats - 3'h1;
    end
    always_ff @(posedge core_clk) beats <= rst ? 3'h0 : next_beats;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_gnt; hs_req && hs_gnt; endsequence
    property p_prio; hs_prio; endproperty
    a_prio: assert property (p_prio) else $error("prio low");
    property p_drop; s_gnt |=> !hs_req; endproperty
    a_drop: assert property (p_drop) else $error("req kept");
    property p_hold; hs_req && !hs_gnt |=> hs_req && $stable(hs_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("req moved");
    // A new burst only once the last one is fully delivered
    property p_space; $rose(hs_req) |-> beats == 3'h0; endproperty
    a_space: assert property (p_space) else $error("overlap");
    property p_cause; pix_valid[0] |-> $past(pix_ready[0]); endproperty
    a_cause: assert property (p_cause) else $error("stray pix");
    property p_order; pal_we |-> !pix_valid[0]; endproperty
    a_order: assert property (p_order) else $error("pix in pal");
    property p_frame; frame_pulse && !hs_req |=> !hs_req; endproperty
    a_frame: assert property (p_frame) else $error("req on frame");
    property p_clear; $fell(underrun_irq) |-> $past(wclr); endproperty
    a_clear: assert property (p_clear) else $error("irq fell");
endmodule : dffd_asserts
`default_nettype wire

// ==== sim/dffd_mem_model.sv ====
// Behavioural frame buffer memory on the system bus
`timescale 1ns/1ps
`default_nettype none
module dffd_mem_model (
    // Clock, reset, test controls
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic [1:0]  psz,
    // Bus slave side
    input  wire logic        hs_req,
    input  wire logic [31:0] hs_addr,
    output logic             hs_gnt,
    output logic             hs_rvalid,
    output logic      [31:0] hs_rdata
);
    logic [31:0] a;
    // Half-word entries; 16-bit mode zero-filled
    function automatic logic [31:0] word(input logic [31:0] a);
        return (psz == 2'h2) ? {2'b00, psz, 12'h0, 2'b00, psz, 12'h0} :
            {2'b00, psz, a[11:0] + 12'h2, 2'b00, psz, a[11:0]};
    endfunction : word
    // Prompt grant, four beats; idle data toggles so stale reads show
    initial begin
        {hs_gnt, hs_rvalid, hs_rdata} = 34'h0;
        forever begin
            @(posedge core_clk);
            hs_rdata <= ~hs_rdata;
            if (hs_req === 1'b1 && !rst) begin
                a = hs_addr;
                hs_gnt <= 1'b1;
                for (int i = 0; i < 4; i++) begin
                    @(posedge core_clk);
                    hs_gnt <= 1'b0;
                    hs_rvalid <= 1'b1;
                    hs_rdata <= word(a + 32'(4 * i));
                    @(posedge core_clk);
                    hs_rvalid <= 1'b0;
                    hs_rdata <= ~hs_rdata;
                    if (slow) repeat (10) @(posedge core_clk);
                end
            end
        end
    end
endmodule : dffd_mem_model
`default_nettype wire

// ==== sim/dffd_top_tb.sv ====
// Self-checking bench of the frame fetch DMA
`timescale 1ns/1ps
`default_nettype none
bind dffd_top dffd_asserts u_chk (.*);
module dffd_top_tb;
    import dffd_pkg::*;
    // Rows: size code, big endian, entries loaded, first entry data
    localparam logic [23:0] ROWS [4] = '{{2'h0, 1'h0, 9'h010, 12'h100},
        {2'h0, 1'h1, 9'h010, 12'h102}, {2'h1, 1'h0, 9'h100, 12'h100},
        {2'h2, 1'h1, 9'h010, 12'h000}};
    logic        core_clk, rst, reg_wr, reg_rd, frame_pulse, slow;
    logic        hs_req, hs_prio, hs_gnt, hs_rvalid, pal_we, underrun_irq;
    logic [7:0]  reg_addr, pal_addr;
    logic [31:0] reg_wdata, reg_rdata, hs_addr, hs_rdata;
    logic [1:0]  pix_ready, pix_valid, pixel_size_select, psz;
    logic [11:0] pal_data, d0;
    logic [15:0] pix_data_top, pix_data_bot;
    int          bad_count, compares, npal, cycles;
    dffd_top u_dut (.*);
    dffd_mem_model u_mem (.*);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic give_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string n, input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge core_clk) reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge core_clk) reg_rd <= 1'b0;
        @(posedge core_clk) chk("reg_rdata", reg_rdata & m, e);
    endtask : rd
    task automatic frame(input logic [31:0] ctrl);
        wr(REG_CTRL, 32'h0);
        frame_pulse <= 1'b1;
        @(posedge core_clk) frame_pulse <= 1'b0;
        npal = 0;
        wr(REG_CTRL, ctrl);
    endtask : frame
    // Palette write monitor and hang limit
    always @(posedge core_clk) begin
        cycles++;
        if (pal_we === 1'b1 && npal == 0) d0 = pal_data;
        if (pal_we === 1'b1) npal++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        {rst, reg_wr, reg_rd, frame_pulse, slow} = 5'h10;
        {reg_addr, reg_wdata, pix_ready, psz} = 44'h0;
        {bad_count, compares, npal, cycles} = '0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(REG_CTRL, 32'h0, 32'h7);
        rd(8'h3c, 32'h0, 32'hffff_ffff);
        chk("hs_req", 32'(hs_req), 32'h0);
        wr(REG_BASE0, 32'h100);
        wr(REG_LEN, 32'h8);
        foreach (ROWS[r]) begin
            psz <= ROWS[r][23:22];
            frame({29'h0, ROWS[r][21], 2'b01});
            for (int i = 0; i < 20 && hs_req !== 1'b1; i++) @(posedge core_clk);
            chk("hs_addr", hs_addr, 32'h100);
            repeat (800) @(posedge core_clk);
            chk("pal count", 32'(npal), 32'(ROWS[r][20:12]));
            chk("pal first", 32'(d0), 32'(ROWS[r][11:0]));
            chk("size", 32'(pixel_size_select), 32'(ROWS[r][23:22]));
            chk("pal last", 32'(pal_addr), 32'(ROWS[r][20:12] - 9'h1));
        end
        // Slow memory with a hungry top panel must run the FIFO dry
        {slow, psz} <= 3'h4;
        wr(REG_LEN, 32'h100);
        frame(32'h1);
        pix_ready <= 2'h1;
        for (int i = 0; i < 3000 && underrun_irq !== 1'b1; i++) @(posedge core_clk);
        chk("underrun", 32'(underrun_irq), 32'h1);
        pix_ready <= 2'h0;
        wr(REG_CTRL, 32'h0);
        rd(REG_STATUS, 32'h1, 32'h1);
        wr(REG_STATUS, 32'h1);
        repeat (2) @(posedge core_clk);
        chk("underrun clr", 32'(underrun_irq), 32'h0);
        give_verdict();
    end
endmodule : dffd_top_tb
`default_nettype wire
